// *** rtl/sotp_pkg.sv ***
// Package of constants shared by both ends of the serial programming port
// How it works
// - Chip select low, opcode then address start programming
// - Opcode bits sent 1,0,0,1,1,0,0,1
// - 24-bit address follows, highest bit first
// - Data byte after address gets programmed
// - Host raises chip select after last byte
// - Further bytes program successive incremented addresses
// - Address counter wraps from top to zero
// - Accept both idle clock levels, modes 0/3
// - Sample serial input on rising clock edge
// - All fields travel most significant bit first
// - Mode chosen at each chip select fall
// - Unknown opcode ignored until chip select rises
package sotp_pkg;
  localparam logic [7:0] SOTP_OP_PROG    = 8'h99;
  localparam int         SOTP_OP_BITS    = 8;
  localparam int         SOTP_ADDR_BITS  = 24;
  localparam int         SOTP_MEM_ABITS  = 16;
  localparam int         SOTP_HDR_BITS   = 32;
  localparam int         SOTP_MCLK_NS    = 50;
  localparam int         SOTP_SCK_HALF_NS = 7500;
  localparam int         SOTP_SCK_HALF_CYC = (SOTP_SCK_HALF_NS + SOTP_MCLK_NS - 1) / SOTP_MCLK_NS;
  localparam int         SOTP_CS_GAP_NS  = 2000;
  localparam int         SOTP_CS_GAP_CYC = (SOTP_CS_GAP_NS + SOTP_MCLK_NS - 1) / SOTP_MCLK_NS;
endpackage : sotp_pkg

// *** rtl/sotp_if.sv ***
// Interface carrying the serial programming link between host and device
`timescale 1ns/1ns
interface sotp_if;
  logic cs_n;
  logic sck;
  logic si;
  modport host   (output cs_n, output sck, output si);
  modport device (input cs_n, input sck, input si);
endinterface : sotp_if

// *** rtl/sotp_device.sv ***
// Device end: decodes the programming frame on the link clock and writes bytes
`timescale 1ns/1ns
module sotp_device
  import sotp_pkg::*;
(
  sotp_if.device           link,
  input  wire logic        mclk,
  input  wire logic        reset,
  output logic             wr_valid_ff,
  output logic [15:0]      wr_addr_ff,
  output logic [7:0]       wr_data_ff,
  output logic             mode3_ff
);
  // Link-domain frame state; counter, shifter, address and flags cleared while chip select is high
  logic [4:0]  bitcnt_ls;
  logic [31:0] shreg_ls;
  logic [15:0] addr_ls;
  logic        hdr_done_ls;
  logic        bad_ls;
  logic        wtog_ls;
  logic [15:0] waddr_ls;
  logic [7:0]  wdata_ls;
  logic        mode_ls;
  logic [31:0] nshift;

  assign nshift = {shreg_ls[30:0], link.si};

  // Mode capture at chip select fall from idle clock level
  always_ff @(negedge link.cs_n or posedge reset) begin
    if (reset) begin
      mode_ls <= 1'b0;
    end else begin
      mode_ls <= link.sck;
    end
  end

  // Bit shifting on rising clock; chip select high ends the frame
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bitcnt_ls   <= 5'h00;
      shreg_ls    <= 32'h0000_0000;
      hdr_done_ls <= 1'b0;
      bad_ls      <= 1'b0;
      addr_ls     <= 16'h0000;
    end else begin
      shreg_ls  <= nshift;
      bitcnt_ls <= bitcnt_ls + 5'h01;
      if (!hdr_done_ls && bitcnt_ls == 5'h07 && nshift[7:0] != SOTP_OP_PROG) begin
        bad_ls <= 1'b1;
      end
      if (!hdr_done_ls && bitcnt_ls == 5'h1F) begin
        hdr_done_ls <= 1'b1;
        bitcnt_ls   <= 5'h00;
        addr_ls     <= nshift[15:0];
      end else if (hdr_done_ls && bitcnt_ls == 5'h07) begin
        bitcnt_ls <= 5'h00;
        addr_ls   <= addr_ls + 16'h0001;
      end
    end
  end

  // Completed data byte handed over by toggle; survives chip select rise
  always_ff @(posedge link.sck or posedge reset) begin
    if (reset) begin
      wtog_ls  <= 1'b0;
      waddr_ls <= 16'h0000;
      wdata_ls <= 8'h00;
    end else if (!link.cs_n && hdr_done_ls && !bad_ls && bitcnt_ls == 5'h07) begin
      wtog_ls  <= ~wtog_ls;
      waddr_ls <= addr_ls;
      wdata_ls <= nshift[7:0];
    end
  end

  // System domain: synchronise toggle and mode, emit write pulse
  logic [2:0] tsync_ff, nxt_tsync;
  logic [1:0] msync_ff, nxt_msync;
  logic       nxt_wr_valid;
  logic [15:0] nxt_wr_addr;
  logic [7:0]  nxt_wr_data;
  logic        nxt_mode3;

  always_comb begin
    nxt_tsync    = {tsync_ff[1:0], wtog_ls};
    nxt_msync    = {msync_ff[0], mode_ls};
    nxt_wr_valid = tsync_ff[2] ^ tsync_ff[1];
    nxt_wr_addr  = wr_addr_ff;
    nxt_wr_data  = wr_data_ff;
    nxt_mode3    = msync_ff[1];
    if (tsync_ff[2] ^ tsync_ff[1]) begin
      nxt_wr_addr = waddr_ls; // Stable for many link cycles after toggle
      nxt_wr_data = wdata_ls;
    end
  end

  // Registers of the system domain
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tsync_ff    <= 3'h0;
      msync_ff    <= 2'h0;
      wr_valid_ff <= 1'b0;
      wr_addr_ff  <= 16'h0000;
      wr_data_ff  <= 8'h00;
      mode3_ff    <= 1'b0;
    end else begin
      tsync_ff    <= nxt_tsync;
      msync_ff    <= nxt_msync;
      wr_valid_ff <= nxt_wr_valid;
      wr_addr_ff  <= nxt_wr_addr;
      wr_data_ff  <= nxt_wr_data;
      mode3_ff    <= nxt_mode3;
    end
  end
endmodule : sotp_device

// *** rtl/sotp_host.sv ***
// Host end: shifts opcode, address and burst of data bytes onto the link
`timescale 1ns/1ns
module sotp_host
  import sotp_pkg::*;
#(
  parameter int HALF_CYC = SOTP_SCK_HALF_CYC,
  parameter int GAP_CYC  = SOTP_CS_GAP_CYC
)(
  sotp_if.host             link,
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic        idle_high,
  input  wire logic [23:0] start_addr,
  input  wire logic [7:0]  byte_data,
  input  wire logic        byte_last,
  output logic             byte_ready_ff,
  output logic             busy_ff,
  output logic             cs_n_ff,
  output logic             sck_ff,
  output logic             si_ff
);
  // Refuse counts that the 16-bit timer cannot hold
  if (HALF_CYC < 1 || HALF_CYC > 65535 || GAP_CYC < 1 || GAP_CYC > 65535) begin : g_bad_count
    $error("sotp_host: counts out of range");
  end

  typedef enum logic [3:0] {
    SOTP_IDLE = 4'b0001, SOTP_SETUP = 4'b0010, SOTP_SHIFT = 4'b0100, SOTP_GAP = 4'b1000
  } sotp_state_e;

  sotp_state_e state_ff, nxt_state;
  logic [31:0] sh_ff, nxt_sh;
  logic [5:0]  bits_ff, nxt_bits;
  logic [15:0] cnt_ff, nxt_cnt;
  logic        last_ff, nxt_last, hdr_ff, nxt_hdr, idle_ff, nxt_idle;
  logic        nxt_cs_n, nxt_sck, nxt_si, nxt_ready, nxt_busy;

  assign link.cs_n = cs_n_ff;
  assign link.sck  = sck_ff;
  assign link.si   = si_ff;

  // Frame sequencer: clock divided from mclk, data changes on falling edge
  always_comb begin
    nxt_state = state_ff;
    nxt_sh    = sh_ff;
    nxt_bits  = bits_ff;
    nxt_cnt   = cnt_ff;
    nxt_last  = last_ff;
    nxt_hdr   = hdr_ff;
    nxt_idle  = idle_ff;
    nxt_cs_n  = cs_n_ff;
    nxt_sck   = sck_ff;
    nxt_si    = si_ff;
    nxt_ready = 1'b0;
    nxt_busy  = (state_ff != SOTP_IDLE);
    case (state_ff)
      SOTP_IDLE: begin
        nxt_sck = idle_high;
        if (start) begin
          nxt_idle  = idle_high;
          nxt_sh    = {SOTP_OP_PROG, start_addr};
          nxt_bits  = 6'd32;
          nxt_hdr   = 1'b1;
          nxt_cs_n  = 1'b0;
          nxt_cnt   = 16'(HALF_CYC);
          nxt_busy  = 1'b1;
          nxt_state = SOTP_SETUP;
        end
      end
      SOTP_SETUP: begin
        nxt_si = sh_ff[31];
        if (cnt_ff == 16'h0001) begin
          nxt_sh    = {sh_ff[30:0], 1'b0};
          nxt_sck   = 1'b0;
          nxt_cnt   = 16'(HALF_CYC);
          nxt_state = SOTP_SHIFT;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      SOTP_SHIFT: begin
        if (cnt_ff != 16'h0001) begin
          nxt_cnt = cnt_ff - 16'h0001;
        end else begin
          nxt_cnt = 16'(HALF_CYC);
          if (!sck_ff) begin
            nxt_sck  = 1'b1;
            nxt_bits = bits_ff - 6'd1;
          end else if (bits_ff == 6'd0 && hdr_ff) begin
            nxt_sck   = 1'b0;
            nxt_hdr   = 1'b0;
            nxt_last  = byte_last;
            nxt_ready = 1'b1;
            nxt_si    = byte_data[7];
            nxt_sh    = {byte_data[6:0], 25'h0000000};
            nxt_bits  = 6'd8;
          end else if (bits_ff == 6'd0 && !last_ff) begin
            nxt_sck   = 1'b0;
            nxt_last  = byte_last;
            nxt_ready = 1'b1;
            nxt_si    = byte_data[7];
            nxt_sh    = {byte_data[6:0], 25'h0000000};
            nxt_bits  = 6'd8;
          end else if (bits_ff == 6'd0) begin
            nxt_sck   = idle_ff;
            nxt_cs_n  = 1'b1;
            nxt_cnt   = 16'(GAP_CYC);
            nxt_state = SOTP_GAP;
          end else begin
            nxt_sck = 1'b0;
            nxt_si  = sh_ff[31];
            nxt_sh  = {sh_ff[30:0], 1'b0};
          end
        end
      end
      SOTP_GAP: begin
        if (cnt_ff == 16'h0001) begin
          nxt_state = SOTP_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      default: nxt_state = SOTP_IDLE;
    endcase
  end

  // Registers of the host sequencer
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_ff      <= SOTP_IDLE;
      sh_ff         <= 32'h0000_0000;
      bits_ff       <= 6'h00;
      cnt_ff        <= 16'h0000;
      last_ff       <= 1'b0;
      hdr_ff        <= 1'b0;
      idle_ff       <= 1'b0;
      cs_n_ff       <= 1'b1;
      sck_ff        <= 1'b0;
      si_ff         <= 1'b0;
      byte_ready_ff <= 1'b0;
      busy_ff       <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      sh_ff         <= nxt_sh;
      bits_ff       <= nxt_bits;
      cnt_ff        <= nxt_cnt;
      last_ff       <= nxt_last;
      hdr_ff        <= nxt_hdr;
      idle_ff       <= nxt_idle;
      cs_n_ff       <= nxt_cs_n;
      sck_ff        <= nxt_sck;
      si_ff         <= nxt_si;
      byte_ready_ff <= nxt_ready;
      busy_ff       <= nxt_busy;
    end
  end
endmodule : sotp_host

// *** testbench/sotp_checker.sv ***
// Checker on the programming link and the device write outputs
`timescale 1ns/1ns
module sotp_checker
  import sotp_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        cs_n,
  input wire logic        sck,
  input wire logic        si,
  input wire logic        wr_valid_ff,
  input wire logic [15:0] wr_addr_ff,
  input wire logic [7:0]  wr_data_ff,
  input wire logic        mode3_ff
);
  logic [7:0]  rise_ff, sh_ff;
  logic [15:0] prev_ff;
  logic [3:0]  bit_ff;
  logic        sck_d_ff, first_ff, mref_ff;
  // Count link clock rises per frame and note the idle level at select
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      {rise_ff, prev_ff, sck_d_ff, first_ff, mref_ff} <= '0;
    end else begin
      sck_d_ff <= sck;
      if ($fell(cs_n)) rise_ff <= 8'h00;
      else if (sck && !sck_d_ff && !cs_n) rise_ff <= rise_ff + 8'h01;
      if ($fell(cs_n)) mref_ff <= sck;
      if (wr_valid_ff) begin
        first_ff <= 1'b0;
        prev_ff  <= wr_addr_ff;
      end else if (cs_n) first_ff <= 1'b1;
    end
  end
  // Opcode shifted on the wire, in the link clock domain
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      {bit_ff, sh_ff} <= '0;
    end else begin
      if (bit_ff != 4'h8) bit_ff <= bit_ff + 4'h1;
      sh_ff <= {sh_ff[6:0], si};
    end
  end
  pulse_one_a: assert property (@(posedge mclk) disable iff (reset)
    wr_valid_ff |=> !wr_valid_ff) else $error("write pulse longer than one cycle");
  addr_step_a: assert property (@(posedge mclk) disable iff (reset)
    wr_valid_ff && !first_ff |-> wr_addr_ff == prev_ff + 16'h0001) else $error("address skipped");
  addr_hold_a: assert property (@(posedge mclk) disable iff (reset)
    !wr_valid_ff |-> $stable(wr_addr_ff) && $stable(wr_data_ff)) else $error("write not held");
  mode_track_a: assert property (@(posedge mclk) disable iff (reset)
    !cs_n [*8] |-> mode3_ff == mref_ff) else $error("clock mode wrong");
  opcode_wire_a: assert property (@(posedge sck) disable iff (cs_n)
    bit_ff == 4'h7 |-> {sh_ff[6:0], si} == SOTP_OP_PROG) else $error("opcode wrong on wire");
  si_stable_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(sck) && !cs_n |-> $stable(si) ##1 $stable(si)) else $error("data moved at rise");
  hdr_first_a: assert property (@(posedge mclk) disable iff (reset)
    wr_valid_ff |-> rise_ff >= 8'h28) else $error("write before header done");
  byte_edge_a: assert property (@(posedge mclk) disable iff (reset)
    wr_valid_ff |-> rise_ff[2:0] == 3'h0) else $error("write off byte boundary");
  cover property (@(posedge mclk) $fell(cs_n) && sck);
  cover property (@(posedge mclk) $fell(cs_n) && !sck);
  cover property (@(posedge mclk) wr_valid_ff && wr_addr_ff == 16'h0000);
endmodule : sotp_checker

// *** testbench/test_serial_otp_program_port.sv ***
// Testbench joining host and device ends over the programming link
`timescale 1ns/1ns
module test_serial_otp_program_port;
  import sotp_pkg::*;
  logic        mclk = 0, reset = 0, start = 0, idle_high = 0, byte_last = 0;
  logic        rdy, busy, wv, m3, v2;
  logic [23:0] start_addr = 24'h000000;
  logic [7:0]  byte_data = 8'h00, wd, d2, bd [3];
  logic [15:0] wa, a2, qa [$];
  logic [7:0]  qd [$];
  int          errors = 0, n_compared = 0, cyc = 0, n2 = 0;
  sotp_if lk ();
  sotp_if l2 ();
  sotp_host #(.HALF_CYC(4), .GAP_CYC(2)) sotp_host_i (.link(lk), .mclk(mclk), .reset(reset),
    .start(start), .idle_high(idle_high), .start_addr(start_addr), .byte_data(byte_data),
    .byte_last(byte_last), .byte_ready_ff(rdy), .busy_ff(busy), .cs_n_ff(), .sck_ff(), .si_ff());
  sotp_device sotp_device_i (.link(lk), .mclk(mclk), .reset(reset), .wr_valid_ff(wv),
    .wr_addr_ff(wa), .wr_data_ff(wd), .mode3_ff(m3));
  sotp_device sotp_device_i2 (.link(l2), .mclk(mclk), .reset(reset), .wr_valid_ff(v2),
    .wr_addr_ff(a2), .wr_data_ff(d2), .mode3_ff());
  sotp_checker sotp_checker_i (.mclk(mclk), .reset(reset), .cs_n(lk.cs_n), .sck(lk.sck), .si(lk.si),
    .wr_valid_ff(wv), .wr_addr_ff(wa), .wr_data_ff(wd), .mode3_ff(m3));
  always #25 mclk = ~mclk;
  // Log writes of the first device, count those of the second, and cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (wv === 1'b1) begin
      qa.push_back(wa);
      qd.push_back(wd);
    end
    if (v2 === 1'b1) n2++;
    if (cyc == 30000) begin
      errors++;
      end_of_test();
    end
  end
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One frame through the host end, bytes taken from bd
  task automatic send(input logic m, input logic [23:0] a, input int n);
    int i, w;
    qa.delete();
    qd.delete();
    idle_high = m;
    start_addr = a;
    repeat (4) @(posedge mclk);
    #2 start = 1;
    for (i = 0; i < n; i++) begin
      byte_data = bd[i];
      byte_last = (i == n - 1);
      w = 0;
      do begin
        @(posedge mclk);
        #2 start = 0;
        w++;
      end while (rdy !== 1'b1 && w < 2000);
      chk("ready", 16'h0001, 16'(rdy));
    end
    w = 0;
    while (busy !== 1'b0 && w < 200) begin
      @(posedge mclk);
      #2 w++;
    end
    chk("busy", 16'h0000, 16'(busy));
  endtask : send
  // Bench-made frame on the second link, mode 0, 160 ns link clock
  task automatic bang(input logic [47:0] v, input int nb);
    int i;
    #300 l2.cs_n = 0;
    for (i = 47; i > 47 - nb; i--) begin
      l2.si = v[i];
      #80 l2.sck = 1;
      #80 l2.sck = 0;
    end
    #300 l2.cs_n = 1;
    l2.si = ~l2.si;
    #2000;
  endtask : bang
  task t_single;
    bd[0] = 8'hA5;
    send(1'b0, 24'hAB1234, 1);
    chk("count", 16'h0001, 16'(qa.size()));
    chk("addr", 16'h1234, qa[0]);
    chk("data", 16'h00A5, 16'(qd[0]));
    chk("mode", 16'h0000, 16'(m3));
    chk("idle", 16'h0002, 16'({lk.cs_n, lk.sck}));
    $display("test single done");
  endtask : t_single
  task t_wrap;
    int i;
    bd = '{8'h11, 8'h22, 8'h33};
    send(1'b1, 24'h00FFFE, 3);
    chk("count", 16'h0003, 16'(qa.size()));
    for (i = 0; i < 3; i++) begin
      chk("addr", 16'(16'hFFFE + i), qa[i]);
      chk("data", 16'(bd[i]), 16'(qd[i]));
    end
    chk("mode", 16'h0001, 16'(m3));
    $display("test wrap done");
  endtask : t_wrap
  task t_refuse;
    bang({8'h03, 24'h000010, 16'hC35A}, 48);
    chk("bad op", 16'h0000, 16'(n2));
    bang({8'h99, 24'h000010, 16'hC35A}, 43);
    chk("partial", 16'h0001, 16'(n2));
    chk("addr2", 16'h0010, a2);
    chk("data2", 16'h00C3, 16'(d2));
    $display("test refuse done");
  endtask : t_refuse
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // Reset, then the scenarios in turn
  initial begin
    {l2.cs_n, l2.sck, l2.si} = 3'h0;
    #1 reset = 1; // Real edges so every asynchronous reset fires
    l2.cs_n = 1;
    repeat (6) @(posedge mclk);
    #2 reset = 0;
    t_single();
    t_wrap();
    t_refuse();
    end_of_test();
  end
endmodule : test_serial_otp_program_port
